// file: src/serial_record_output.sv
/*
  Serial record output: takes record bytes on a valid/ready stream and
  either sends them as asynchronous characters with a terminator, or
  writes them to the internal store. Settings are held in APB registers.
  Assumes 50 MHz clk, synchronous active-high sys_rst, one APB master.
*/
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module serial_record_output (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rec_valid,
   input wire logic [7:0] rec_data,
   input wire logic rec_last,
   output logic rec_ready,
   output logic txd
);
   typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} tx_state_e;
   typedef enum logic [1:0] {PH_REC, PH_CR, PH_LF} phase_e;

   typedef struct packed {
      logic [serial_record_output_pkg::CTRL_W-1:0] ctrl;
      tx_state_e state;
      phase_e phase;
      logic [7:0] shift;
      logic par_bit;
      logic last;
      logic [3:0] bitcnt;
      logic [serial_record_output_pkg::DIV_W-1:0] cnt;
      logic [serial_record_output_pkg::MEM_AW-1:0] wr_ptr;
      logic [serial_record_output_pkg::MEM_AW-1:0] mem_addr;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic txd;
      logic rec_ready;
   } state_s;

   // Defaults: serial out, 38400, no parity, CR/LF
   localparam logic [serial_record_output_pkg::CTRL_W-1:0] CTRL_RST = {
      serial_record_output_pkg::END_CRLF, serial_record_output_pkg::PAR_NONE,
      serial_record_output_pkg::SEL_38400, serial_record_output_pkg::DEST_SERIAL};

   localparam state_s RST_S = '{ctrl: CTRL_RST, state: TX_IDLE, phase: PH_REC,
      shift: '0, par_bit: 1'b0, last: 1'b0, bitcnt: '0, cnt: '0, wr_ptr: '0,
      mem_addr: '0, pready: 1'b0, pslverr: 1'b0, prdata: '0, txd: 1'b1,
      rec_ready: 1'b1};

   // Clock cycles per bit, minus one, for a rate selector code
   function automatic logic [serial_record_output_pkg::DIV_W-1:0] baud_div(
         input logic [2:0] sel);
      int unsigned rate;
      unique case (sel)
         serial_record_output_pkg::SEL_2400: rate = serial_record_output_pkg::RATE_2400;
         serial_record_output_pkg::SEL_4800: rate = serial_record_output_pkg::RATE_4800;
         serial_record_output_pkg::SEL_9600: rate = serial_record_output_pkg::RATE_9600;
         serial_record_output_pkg::SEL_19200: rate = serial_record_output_pkg::RATE_19200;
         serial_record_output_pkg::SEL_38400: rate = serial_record_output_pkg::RATE_38400;
         serial_record_output_pkg::SEL_57600: rate = serial_record_output_pkg::RATE_57600;
         default: rate = serial_record_output_pkg::RATE_115200;
      endcase
      return serial_record_output_pkg::DIV_W'(serial_record_output_pkg::CLK_HZ / rate - 1);
   endfunction

   state_s s_reg;
   state_s s_next;
   logic take;
   logic mem_we;
   logic dest_mem;
   logic par_en;
   logic par_odd;
   logic [3:0] nbits;
   logic [serial_record_output_pkg::DIV_W-1:0] div;
   logic [serial_record_output_pkg::MEM_DW-1:0] mem_rdata;

   ////////////////////////////////////////////////////////////////////////////
   // Decoded settings; rate and format are read live, so change them idle
   assign dest_mem = s_reg.ctrl[serial_record_output_pkg::DEST_BIT];
   assign par_odd = s_reg.ctrl[serial_record_output_pkg::PAR_LSB +: 2] ==
      serial_record_output_pkg::PAR_ODD;
   assign par_en = par_odd || s_reg.ctrl[serial_record_output_pkg::PAR_LSB +: 2] ==
      serial_record_output_pkg::PAR_EVEN;
   assign nbits = par_en ? serial_record_output_pkg::DBITS_PAR
      : serial_record_output_pkg::DBITS_NOPAR;
   assign div = baud_div(s_reg.ctrl[serial_record_output_pkg::BAUD_LSB +: 3]);
   assign take = rec_valid && s_reg.rec_ready;
   assign mem_we = take && dest_mem;

   record_store u_store (
      .clk(clk),
      .sys_rst(sys_rst),
      .we(mem_we),
      .waddr(s_reg.wr_ptr),
      .wdata(rec_data),
      .raddr(s_reg.mem_addr),
      .rdata(mem_rdata)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Next state: APB slave, then the character sequencer
   always_comb begin
      logic [7:0] ch;
      logic load;
      s_next = s_reg;
      ch = serial_record_output_pkg::CHAR_CR;
      load = 1'b0;
      // APB: one wait cycle, pready pulses for one edge
      s_next.pready = psel && penable && !s_reg.pready;
      s_next.pslverr = 1'b0;
      if (psel && penable && !s_reg.pready) begin
         s_next.prdata = '0;
         unique case (paddr)
            serial_record_output_pkg::OFS_CTRL:
               s_next.prdata[serial_record_output_pkg::CTRL_W-1:0] = s_reg.ctrl;
            serial_record_output_pkg::OFS_STATUS: begin
               s_next.prdata[serial_record_output_pkg::STAT_BUSY_BIT] =
                  s_reg.state != TX_IDLE || s_reg.phase != PH_REC;
               s_next.prdata[serial_record_output_pkg::STAT_DBITS_LSB +: 4] = nbits;
               s_next.prdata[serial_record_output_pkg::STAT_WPTR_LSB +:
                  serial_record_output_pkg::MEM_AW] = s_reg.wr_ptr;
            end
            serial_record_output_pkg::OFS_MEM_ADDR:
               s_next.prdata[serial_record_output_pkg::MEM_AW-1:0] = s_reg.mem_addr;
            serial_record_output_pkg::OFS_MEM_DATA:
               s_next.prdata[serial_record_output_pkg::MEM_DW-1:0] = mem_rdata;
            default: s_next.pslverr = 1'b1;
         endcase
      end
      // Writes take effect at the edge where pready is seen high
      if (psel && penable && s_reg.pready && pwrite) begin
         if (paddr == serial_record_output_pkg::OFS_CTRL) begin
            s_next.ctrl = pwdata[serial_record_output_pkg::CTRL_W-1:0];
         end
         if (paddr == serial_record_output_pkg::OFS_MEM_ADDR) begin
            s_next.mem_addr = pwdata[serial_record_output_pkg::MEM_AW-1:0];
         end
      end
      // Internal store: pointer wraps, oldest bytes are overwritten
      if (mem_we) begin
         s_next.wr_ptr = s_reg.wr_ptr + 1'b1;
      end
      // Character sequencer
      unique case (s_reg.state)
         TX_IDLE: begin
            if (take && !dest_mem) begin
               ch = rec_data;
               s_next.last = rec_last;
               load = 1'b1;
            end else if (s_reg.phase != PH_REC) begin
               ch = (s_reg.phase == PH_CR) ? serial_record_output_pkg::CHAR_CR
                  : serial_record_output_pkg::CHAR_LF;
               load = 1'b1;
            end
         end
         default: begin
            if (s_reg.cnt != '0) begin
               s_next.cnt = s_reg.cnt - 1'b1;
            end else begin
               s_next.cnt = div;
               unique case (s_reg.state)
                  TX_START: begin
                     s_next.state = TX_DATA;
                     s_next.bitcnt = '0;
                  end
                  TX_DATA: begin
                     s_next.shift = {1'b0, s_reg.shift[7:1]};
                     s_next.bitcnt = s_reg.bitcnt + 1'b1;
                     if (s_reg.bitcnt == nbits - 1'b1) begin
                        s_next.state = par_en ? TX_PARITY : TX_STOP;
                     end
                  end
                  TX_PARITY: s_next.state = TX_STOP;
                  default: begin
                     // One stop bit then idle
                     s_next.state = TX_IDLE;
                     unique case (s_reg.phase)
                        PH_REC: s_next.phase = s_reg.last ? PH_CR : PH_REC;
                        PH_CR: s_next.phase = s_reg.ctrl[serial_record_output_pkg::END_BIT]
                           ? PH_REC : PH_LF;
                        default: s_next.phase = PH_REC;
                     endcase
                  end
               endcase
            end
         end
      endcase
      if (load) begin
         s_next.shift = ch;
         s_next.par_bit = (^ch[serial_record_output_pkg::DBITS_PAR-1:0]) ^ par_odd;
         s_next.state = TX_START;
         s_next.cnt = div;
      end
      // Line level follows the next state so txd lines up with state
      unique case (s_next.state)
         TX_START: s_next.txd = 1'b0;
         TX_DATA: s_next.txd = s_next.shift[0];
         TX_PARITY: s_next.txd = s_next.par_bit;
         default: s_next.txd = 1'b1;
      endcase
      s_next.rec_ready = s_next.state == TX_IDLE && s_next.phase == PH_REC;
   end

   // State register
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_reg <= RST_S;
      end else begin
         s_reg <= s_next;
      end
   end

   assign prdata = s_reg.prdata;
   assign pready = s_reg.pready;
   assign pslverr = s_reg.pslverr;
   assign rec_ready = s_reg.rec_ready;
   assign txd = s_reg.txd;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence s_stop_done;
      s_reg.state == TX_STOP && s_reg.cnt == '0;
   endsequence
   sequence s_back_idle;
      ##1 s_reg.state == TX_IDLE;
   endsequence

   property p_rate;
      $rose(s_reg.state == TX_START) |-> s_reg.cnt == div;
   endproperty
   a_rate: assert property (p_rate) else $error("bit period not reloaded");

   // Only the first parity cycle looks back at the last data bit count
   property p_width;
      $rose(s_reg.state == TX_PARITY) |->
         $past(s_reg.bitcnt) == serial_record_output_pkg::DBITS_PAR - 1'b1;
   endproperty
   a_width: assert property (p_width) else $error("parity after wrong bit count");

   property p_parity;
      s_reg.state == TX_PARITY |-> par_en && txd == s_reg.par_bit;
   endproperty
   a_parity: assert property (p_parity) else $error("bad parity bit");

   property p_stop;
      s_stop_done |-> s_back_idle;
   endproperty
   a_stop: assert property (p_stop) else $error("more than one stop bit");

   property p_term;
      s_reg.phase == PH_LF |-> !s_reg.ctrl[serial_record_output_pkg::END_BIT];
   endproperty
   a_term: assert property (p_term) else $error("line feed sent in CR mode");

   property p_reset;
      $past(sys_rst) |-> s_reg.ctrl == CTRL_RST && txd;
   endproperty
   a_reset: assert property (p_reset) else $error("wrong reset settings");

   property p_send;
      take && !dest_mem |=> s_reg.state == TX_START ##1 !txd;
   endproperty
   a_send: assert property (p_send) else $error("record byte not sent");

   property p_mem;
      mem_we |=> s_reg.state == TX_IDLE && txd && s_reg.wr_ptr == $past(s_reg.wr_ptr) + 1'b1;
   endproperty
   a_mem: assert property (p_mem) else $error("memory record leaked to line");

   property p_frame;
      $rose(s_reg.state == TX_DATA) |-> $past(txd) == 1'b0 ##0 $past(s_reg.state) == TX_START;
   endproperty
   a_frame: assert property (p_frame) else $error("data without start bit");
endmodule
`default_nettype wire

// file: src/serial_record_output_pkg.sv
/*
  Constants shared by the serial record output block: register map, field
  positions, reset values, line characters and bit-rate figures.
  Assumes a 50 MHz system clock and an APB master with 32-bit data.
*/
// What this block does
// - Bit rate selectable 2400 up to 115200
// - Seven data bits with parity, eight without
// - Parity none, even or odd, after data
// - Exactly one stop bit per character
// - Record ends with CR/LF or CR alone
// - Reset: 8N1, CR/LF, variant default rate
// - Serial destination sends every record out
// - Memory destination stores records, line stays silent
package serial_record_output_pkg;
   // Clock and bit rates, in Hz and bits per second
   localparam int unsigned CLK_HZ = 50_000_000;
   localparam int unsigned RATE_2400 = 2400;
   localparam int unsigned RATE_4800 = 4800;
   localparam int unsigned RATE_9600 = 9600;
   localparam int unsigned RATE_19200 = 19200;
   localparam int unsigned RATE_38400 = 38400;
   localparam int unsigned RATE_57600 = 57600;
   localparam int unsigned RATE_115200 = 115200;
   localparam int DIV_W = 16;
   // Rate selector codes
   localparam logic [2:0] SEL_2400 = 3'h0;
   localparam logic [2:0] SEL_4800 = 3'h1;
   localparam logic [2:0] SEL_9600 = 3'h2;
   localparam logic [2:0] SEL_19200 = 3'h3;
   localparam logic [2:0] SEL_38400 = 3'h4;
   localparam logic [2:0] SEL_57600 = 3'h5;
   localparam logic [2:0] SEL_115200 = 3'h6;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_MEM_ADDR = 8'h08;
   localparam logic [7:0] OFS_MEM_DATA = 8'h0C;
   // Control fields
   localparam int CTRL_W = 7;
   localparam int DEST_BIT = 0;
   localparam int BAUD_LSB = 1;
   localparam int PAR_LSB = 4;
   localparam int END_BIT = 6;
   localparam logic [1:0] PAR_NONE = 2'h0;
   localparam logic [1:0] PAR_EVEN = 2'h1;
   localparam logic [1:0] PAR_ODD = 2'h2;
   localparam logic DEST_SERIAL = 1'b0;
   localparam logic END_CRLF = 1'b0;
   // Status fields
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_DBITS_LSB = 4;
   localparam int STAT_WPTR_LSB = 16;
   // Character widths and terminator bytes
   localparam logic [3:0] DBITS_PAR = 4'h7;
   localparam logic [3:0] DBITS_NOPAR = 4'h8;
   localparam logic [7:0] CHAR_CR = 8'h0D;
   localparam logic [7:0] CHAR_LF = 8'h0A;
   // Internal record store
   localparam int MEM_AW = 10;
   localparam int MEM_DW = 8;
endpackage

// file: src/record_store.sv
/*
  Internal record store: one write port, one read port whose data comes
  out of a register one edge after the address.
  Assumes a single clock and a synchronous, active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module record_store (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic we,
   input wire logic [serial_record_output_pkg::MEM_AW-1:0] waddr,
   input wire logic [serial_record_output_pkg::MEM_DW-1:0] wdata,
   input wire logic [serial_record_output_pkg::MEM_AW-1:0] raddr,
   output logic [serial_record_output_pkg::MEM_DW-1:0] rdata
);
   logic [serial_record_output_pkg::MEM_DW-1:0] mem [2**serial_record_output_pkg::MEM_AW];

   ////////////////////////////////////////////////////////////////////////////
   // Array has no reset so it can map onto block RAM
   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   // Registered read port
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rdata <= '0;
      end else begin
         rdata <= mem[raddr];
      end
   end
endmodule
`default_nettype wire

// file: test/serial_sink.sv
/*
  Receiving end of the serial line: samples each character at mid-bit
  and queues what it received for the bench to compare.
  Assumes the bench sets bit_cyc, nbits and par to match the block.
*/
`timescale 1ns/1ps
`default_nettype none
module serial_sink (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic txd,
   input wire logic [15:0] bit_cyc,
   input wire logic [3:0] nbits,
   input wire logic [1:0] par
);
   logic [7:0] got [$];
   int n_bad = 0;
   logic [7:0] sh;
   logic cut;
   int e;
   int i;
   ////////////////////////////////////////////////////////////////////////
   // Waits n cycles; a reset mid-frame cuts the frame short
   task automatic hold(input int n);
      int k;
      for (k = 0; k < n && !cut; k++) begin
         @(posedge clk);
         if (sys_rst) cut = 1'b1;
      end
   endtask
   // One frame per falling edge, sampled at the agreed rate
   always begin
      @(negedge txd);
      cut = 1'b0;
      e = 0;
      sh = 8'h00;
      hold(bit_cyc / 2);
      if (txd !== 1'b0) e++;
      for (i = 0; i < nbits; i++) begin
         hold(bit_cyc);
         sh[i] = txd;
      end
      if (^par) begin
         hold(bit_cyc);
         if ((^sh ^ txd) !== par[1]) e++;
      end
      hold(bit_cyc);
      if (txd !== 1'b1) e++;
      // A cut frame is dropped rather than judged
      if (!cut) begin
         n_bad += e;
         got.push_back(sh);
      end
   end
endmodule
`default_nettype wire

// file: test/testbench.sv
/*
  Self-checking bench for the serial record output block.
  Assumes the block, the serial sink model and one 50 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
   typedef struct {logic [6:0] ctrl; logic [7:0] d; logic l;} row_s;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic pready;
   logic pslverr;
   logic er;
   logic rec_valid = 1'b0;
   logic rec_last = 1'b0;
   logic [7:0] rec_data = 8'h00;
   logic rec_ready;
   logic txd;
   logic [15:0] bit_cyc = 16'h0516;
   logic [3:0] nbits = 4'h8;
   logic [1:0] par = 2'h0;
   int n_mismatch = 0;
   int num_checks = 0;
   int n_low = 0;
   logic [7:0] exp [$];
   // Rate select 6 or 5 only: slower rates would make the run too long
   row_s rows [4] = '{'{7'h0C, 8'hA5, 1'b1}, '{7'h5C, 8'hD3, 1'b1},
      '{7'h6C, 8'hC4, 1'b0}, '{7'h7A, 8'h81, 1'b1}};
   serial_record_output i_serial_record_output (.clk(clk), .sys_rst(sys_rst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .rec_valid(rec_valid),
      .rec_data(rec_data), .rec_last(rec_last), .rec_ready(rec_ready), .txd(txd));
   serial_sink i_serial_sink (.clk(clk), .sys_rst(sys_rst), .txd(txd),
      .bit_cyc(bit_cyc), .nbits(nbits), .par(par));
   ////////////////////////////////////////////////////////////////////////
   // Clock and line watch
   always #10 clk = ~clk;
   always @(negedge clk) if (txd !== 1'b1) n_low++;
   ////////////////////////////////////////////////////////////////////////
   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic fail();
      n_mismatch++;
      $display("[ERR] %0t wait timed out", $time);
      results();
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] want, input string m);
      num_checks++;
      if (got !== want) begin
         n_mismatch++;
         $display("[ERR] %0t %s got %h want %h", $time, m, got, want);
      end
   endtask
   // One APB transfer; an idle edge first keeps psel from two writes at once
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      for (k = 0; k < 50; k++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      if (k == 50) fail();
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Offers one byte; valid stays up so bytes can follow back to back
   task automatic put(input logic [7:0] d, input logic l);
      int k;
      rec_valid <= 1'b1;
      rec_data <= d;
      rec_last <= l;
      for (k = 0; k < 99999; k++) begin
         @(posedge clk);
         if (rec_ready === 1'b1) break;
      end
      if (k == 99999) fail();
   endtask
   // Times one start bit against the rate, then cuts the frame with a reset:
   // slow rates stay cheap this way, and the line must go idle at once
   task automatic start_bit(input int unsigned rt);
      int k;
      int w;
      int cyc;
      cyc = serial_record_output_pkg::CLK_HZ / rt;
      put(8'h01, 1'b0);
      rec_valid <= 1'b0;
      for (k = 0; k < 2000 && txd !== 1'b0; k++) @(negedge clk);
      if (k == 2000) fail();
      for (w = 0; w < 30000 && txd === 1'b0; w++) @(negedge clk);
      chk(32'(w >= cyc - 1 && w <= cyc + 1), 32'h1, "start width");
      @(posedge clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      @(negedge clk);
      chk({31'h0, txd}, 32'h1, "idle after reset");
   endtask
   // Settings may only change once the line is idle
   task automatic settle();
      int k;
      for (k = 0; k < 300; k++) begin
         apb(1'b0, serial_record_output_pkg::OFS_STATUS, 32'h0);
         if (rd[0] === 1'b0) return;
      end
      fail();
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      int k;
      int unsigned rt;
      logic on;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      // Reset settings, then the width of one start bit at the default rate
      apb(1'b0, serial_record_output_pkg::OFS_CTRL, 32'h0);
      chk(rd, 32'h00000008, "ctrl reset");
      chk({31'h0, er}, 32'h0, "mapped err");
      apb(1'b0, serial_record_output_pkg::OFS_STATUS, 32'h0);
      chk({28'h0, rd[7:4]}, 32'h8, "dbits reset");
      // Start bit at the default rate, then at slower rates set by software
      start_bit(serial_record_output_pkg::RATE_38400);
      apb(1'b1, serial_record_output_pkg::OFS_CTRL, 32'h00000006);
      start_bit(serial_record_output_pkg::RATE_19200);
      apb(1'b1, serial_record_output_pkg::OFS_CTRL, 32'h00000004);
      start_bit(serial_record_output_pkg::RATE_9600);
      apb(1'b1, serial_record_output_pkg::OFS_CTRL, 32'h00000002);
      start_bit(serial_record_output_pkg::RATE_4800);
      // Table of records: rate, parity, width and terminator per row
      foreach (rows[r]) begin
         on = ^rows[r].ctrl[5:4];
         rt = rows[r].ctrl[3:1] == 3'h5 ? serial_record_output_pkg::RATE_57600 :
            serial_record_output_pkg::RATE_115200;
         bit_cyc <= 16'(serial_record_output_pkg::CLK_HZ / rt);
         nbits <= on ? 4'h7 : 4'h8;
         par <= rows[r].ctrl[5:4];
         exp.delete();
         exp.push_back(on ? {1'b0, rows[r].d[6:0]} : rows[r].d);
         if (rows[r].l) exp.push_back(serial_record_output_pkg::CHAR_CR);
         if (rows[r].l && !rows[r].ctrl[6]) exp.push_back(serial_record_output_pkg::CHAR_LF);
         settle();
         apb(1'b1, serial_record_output_pkg::OFS_CTRL, {25'h0, rows[r].ctrl});
         apb(1'b0, serial_record_output_pkg::OFS_STATUS, 32'h0);
         chk({28'h0, rd[7:4]}, on ? 32'h7 : 32'h8, "dbits");
         i_serial_sink.got.delete();
         put(rows[r].d, rows[r].l);
         rec_valid <= 1'b0;
         for (k = 0; k < 60000 && i_serial_sink.got.size() < exp.size(); k++) @(posedge clk);
         if (k == 60000) fail();
         foreach (exp[j]) chk({24'h0, i_serial_sink.got[j]}, {24'h0, exp[j]}, "char");
      end
      chk(i_serial_sink.n_bad, 32'h0, "framing");
      // Memory destination: bytes stored, line silent
      settle();
      apb(1'b1, serial_record_output_pkg::OFS_CTRL, 32'h00000001);
      n_low = 0;
      put(8'h11, 1'b0);
      put(8'h22, 1'b0);
      put(8'h33, 1'b1);
      rec_valid <= 1'b0;
      apb(1'b0, serial_record_output_pkg::OFS_STATUS, 32'h0);
      chk({22'h0, rd[25:16]}, 32'h3, "write pointer");
      apb(1'b1, serial_record_output_pkg::OFS_MEM_ADDR, 32'h00000001);
      apb(1'b0, serial_record_output_pkg::OFS_MEM_DATA, 32'h0);
      chk(rd, 32'h00000022, "stored byte");
      chk(n_low, 32'h0, "line quiet");
      apb(1'b0, 8'h10, 32'h0);
      chk({31'h0, er}, 32'h1, "unmapped err");
      results();
   end
endmodule
`default_nettype wire
